// File: src/acs_clk_if.sv
// Link between the sequencer and its converter-clock divider.
// Assumes both ends share one clock.
`default_nettype none

interface acs_clk_if;
  logic                     run;
  logic [acs_pkg::PRE_W-1:0] factor_sel;
  logic                     tick;

  modport ctl (output run, output factor_sel, input tick);
  modport div (input run, input factor_sel, output tick);
endinterface : acs_clk_if

`default_nettype wire

// File: src/acs_divider.sv
// Converter-clock prescaler: a one-cycle tick marks each rising converter-clock edge.
// Assumes run drops whenever the block is disabled or idle.
`default_nettype none

module acs_divider (
  input  wire logic CLK,
  input  wire logic RESETN,
  acs_clk_if.div    lnk
);
  import acs_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } acs_div_s;

  acs_div_s s_q;
  acs_div_s s_d;
  logic [DIV_W-1:0] half;

  always_comb begin
    half = acs_half_factor(lnk.factor_sel);
    s_d  = s_q;
    s_d.tick = 1'b0;
    if (!lnk.run) begin
      s_d.cnt = '0;
    end else begin
      // Rising edge half a period in, so the start delay is fixed
      s_d.tick = (s_q.cnt == half - DIV_W'(1));
      if (s_q.cnt == (half << 1) - DIV_W'(1)) begin
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.tick = s_q.tick;

endmodule : acs_divider

`default_nettype wire

// File: src/acs_pkg.sv
// Constants, register map and field layout of the conversion sequencer.
// Assumes an APB master with 32-bit data and byte addresses on PADDR.
//
// Notes on behaviour
// - Writing start launches a conversion; bit reads one while busy, single mode clears it.
// - A channel change mid-conversion waits until the running conversion ends.
// - Completion sets result-ready; interrupt needs its enable and global enable.
// - Result-ready is set on every completion, even with its enable cleared.
// - With event start enabled, a routed event edge while idle starts a conversion.
// - Event input is edge sensitive; it sets the start bit, cleared on completion in single mode.
// - Free-running: start write begins, each completion restarts and sets result-ready.
// - Prescaler divides by the selected factor, runs when enabled and busy, held zero otherwise.
// - Prescaler held reset when idle; start delay is half factor plus two.
// - Plain conversion lasts 13 converter cycles; sample-hold two cycles after start.
// - Completion loads result and sets flag; reading result or writing one clears it.
// - Sampling lasts two plus sample delay plus sample length converter cycles.
// - Free-running period is 13 plus delay plus length cycles, no gap.
// - Channel and reference go to holding registers, copied to active while idle or waiting to start.
// - Active selection frozen at start, copying resumes in the final converter cycle.
// - Free-running channel change takes effect from the conversion after next.
// - While enabled, each new result gives a one-clock result-ready event pulse.
// - Result is a 10-bit value, right-adjusted in the result register.
`default_nettype none

package acs_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned RES_W = 10;
  localparam int unsigned CH_W = 5;
  localparam int unsigned REF_W = 3;
  localparam int unsigned PRE_W = 3;
  localparam int unsigned DLY_W = 4;
  localparam int unsigned LEN_W = 5;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned DIV_W = 8;

  // Register byte addresses
  localparam logic [AW-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [AW-1:0] ADDR_CHANNEL = 8'h04;
  localparam logic [AW-1:0] ADDR_REF     = 8'h08;
  localparam logic [AW-1:0] ADDR_CLOCK_DIVIDER_SELECT   = 8'h0c;
  localparam logic [AW-1:0] ADDR_SAMPLE_LENGTH_FIELD = 8'h10;
  localparam logic [AW-1:0] ADDR_SAMPLE_DELAY_FIELD = 8'h14;
  localparam logic [AW-1:0] ADDR_EVENT_CONTROL_REGISTER  = 8'h18;
  localparam logic [AW-1:0] ADDR_COMMAND = 8'h1c;
  localparam logic [AW-1:0] ADDR_INTEN   = 8'h20;
  localparam logic [AW-1:0] ADDR_INTERRUPT_FLAG_REGISTER = 8'h24;
  localparam logic [AW-1:0] ADDR_RESULT  = 8'h28;
  localparam logic [AW-1:0] ADDR_STATUS  = 8'h2c;

  // Bit positions
  localparam int unsigned BIT_ENABLE   = 0;
  localparam int unsigned BIT_CONTIN   = 1;
  localparam int unsigned BIT_ONE      = 0;
  localparam int unsigned STAT_CH_LSB  = 0;
  localparam int unsigned STAT_REF_LSB = 8;
  localparam int unsigned STAT_BUSY    = 16;

  // Timing in converter-clock cycles
  localparam logic [CNT_W-1:0] CONV_CYCLES = 7'h0d;
  localparam logic [CNT_W-1:0] SAMPLE_BASE = 7'h02;

  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } acs_state_e;

  // Division factor is 2 to the power of (select + 1)
  function automatic logic [DIV_W-1:0] acs_half_factor(input logic [PRE_W-1:0] sel);
    acs_half_factor = DIV_W'(1) << sel;
  endfunction : acs_half_factor

endpackage : acs_pkg

`default_nettype wire

// File: src/acs_sequencer.sv
// Conversion sequencer top: APB registers, start logic, conversion timing,
// selection locking and result capture.
// Assumes the analog core presents a settled result on CORE_RESULT at completion.
`default_nettype none

module acs_sequencer (
  input  wire logic                         CLK,
  input  wire logic                         RESETN,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [acs_pkg::AW-1:0]       PADDR,
  input  wire logic [acs_pkg::DW-1:0]       PWDATA,
  output logic      [acs_pkg::DW-1:0]       PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  input  wire logic                         EVENT_IN,
  input  wire logic                         GLOBAL_IE,
  input  wire logic [acs_pkg::RES_W-1:0]    CORE_RESULT,
  output logic                              CONV_ACTIVE,
  output logic                              SAMPLE_HOLD,
  output logic      [acs_pkg::CH_W-1:0]     ACTIVE_CHANNEL,
  output logic      [acs_pkg::REF_W-1:0]    ACTIVE_REFERENCE,
  output logic                              RESULT_EVENT,
  output logic                              IRQ
);
  import acs_pkg::*;

  typedef struct packed {
    acs_state_e        state;
    logic              enable;
    logic              contin;
    logic [CH_W-1:0]   hold_ch;
    logic [REF_W-1:0]  hold_ref;
    logic [CH_W-1:0]   snap_ch;
    logic [REF_W-1:0]  snap_ref;
    logic [CH_W-1:0]   act_ch;
    logic [REF_W-1:0]  act_ref;
    logic [PRE_W-1:0]  clock_divider_select;
    logic [LEN_W-1:0]  sample_length_field;
    logic [DLY_W-1:0]  sample_delay_field;
    logic              ev_en;
    logic              ev_prev;
    logic              start;
    logic              rr_ie;
    logic              rr_flag;
    logic [RES_W-1:0]  result;
    logic [CNT_W-1:0]  cnt;
    logic              sh;
    logic              res_ev;
    logic              irq;
    logic              conv;
    logic              run;
    logic [DW-1:0]     rdata;
    logic              ready;
    logic              slverr;
  } acs_seq_s;

  acs_seq_s s_q;
  acs_seq_s s_d;

  acs_clk_if clk_lnk ();

  acs_divider u_div (
    .CLK    (CLK),
    .RESETN (RESETN),
    .lnk    (clk_lnk.div)
  );

  function automatic logic acs_mapped(input logic [AW-1:0] a);
    case (a)
      ADDR_CTRL, ADDR_CHANNEL, ADDR_REF, ADDR_CLOCK_DIVIDER_SELECT, ADDR_SAMPLE_LENGTH_FIELD, ADDR_SAMPLE_DELAY_FIELD,
      ADDR_EVENT_CONTROL_REGISTER, ADDR_COMMAND, ADDR_INTEN, ADDR_INTERRUPT_FLAG_REGISTER, ADDR_RESULT,
      ADDR_STATUS: acs_mapped = 1'b1;
      default:     acs_mapped = 1'b0;
    endcase
  endfunction : acs_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic             setup;
  logic             wr;
  logic             rd;
  logic             ev_edge;
  logic [CNT_W-1:0] total;
  logic             last_cycle;
  logic             done;
  logic             go;
  logic             rr_clr;

  always_comb begin
    s_d        = s_q;
    setup      = PSEL && !PENABLE;
    wr         = PSEL && PENABLE && PREADY && PWRITE && acs_mapped(PADDR);
    rd         = PSEL && PENABLE && PREADY && !PWRITE;
    ev_edge    = EVENT_IN && !s_q.ev_prev;
    total      = CONV_CYCLES + CNT_W'(s_q.sample_delay_field) + CNT_W'(s_q.sample_length_field);
    last_cycle = (s_q.state == ST_CONV) && (s_q.cnt == total - CNT_W'(1));
    done       = last_cycle && clk_lnk.tick;
    go         = 1'b0;
    rr_clr     = 1'b0;

    s_d.ev_prev = EVENT_IN;
    s_d.sh      = 1'b0;
    s_d.res_ev  = 1'b0;

    // Register writes
    if (wr) begin
      case (PADDR)
        ADDR_CTRL: begin
          s_d.enable = PWDATA[BIT_ENABLE];
          s_d.contin = PWDATA[BIT_CONTIN];
        end
        ADDR_CHANNEL: s_d.hold_ch  = PWDATA[CH_W-1:0];
        ADDR_REF:     s_d.hold_ref = PWDATA[REF_W-1:0];
        ADDR_CLOCK_DIVIDER_SELECT:   s_d.clock_divider_select    = PWDATA[PRE_W-1:0];
        ADDR_SAMPLE_LENGTH_FIELD: s_d.sample_length_field  = PWDATA[LEN_W-1:0];
        ADDR_SAMPLE_DELAY_FIELD: s_d.sample_delay_field  = PWDATA[DLY_W-1:0];
        ADDR_EVENT_CONTROL_REGISTER:  s_d.ev_en    = PWDATA[BIT_ONE];
        ADDR_INTEN:   s_d.rr_ie    = PWDATA[BIT_ONE];
        ADDR_COMMAND: begin
          // A one while busy changes nothing
          if (PWDATA[BIT_ONE] && s_q.state == ST_IDLE) begin
            go = 1'b1;
          end else if (!PWDATA[BIT_ONE] && s_q.contin) begin
            s_d.start = 1'b0;
          end
        end
        ADDR_INTERRUPT_FLAG_REGISTER: rr_clr = PWDATA[BIT_ONE];
        default: ;
      endcase
    end
    if (rd && PADDR == ADDR_RESULT) begin
      rr_clr = 1'b1;
    end
    if (s_q.ev_en && ev_edge && s_q.state == ST_IDLE) begin
      go = 1'b1;
    end

    // Sequencing in converter-clock ticks
    case (s_q.state)
      ST_IDLE: begin
        s_d.act_ch  = s_q.hold_ch;
        s_d.act_ref = s_q.hold_ref;
        if (go && s_q.enable) begin
          s_d.start = 1'b1;
          s_d.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        s_d.act_ch  = s_q.hold_ch;
        s_d.act_ref = s_q.hold_ref;
        if (clk_lnk.tick) begin
          // Frozen from here on
          s_d.state    = ST_CONV;
          s_d.cnt      = '0;
          s_d.snap_ch  = s_q.hold_ch;
          s_d.snap_ref = s_q.hold_ref;
        end
      end
      ST_CONV: begin
        if (last_cycle) begin
          // Free-running restart uses the selection caught at this start
          s_d.act_ch  = s_q.contin ? s_q.snap_ch : s_q.hold_ch;
          s_d.act_ref = s_q.contin ? s_q.snap_ref : s_q.hold_ref;
        end
        if (clk_lnk.tick) begin
          if (s_q.cnt + CNT_W'(1) ==
              SAMPLE_BASE + CNT_W'(s_q.sample_delay_field) + CNT_W'(s_q.sample_length_field)) begin
            s_d.sh = 1'b1;
          end
          if (done) begin
            s_d.result = CORE_RESULT;
            s_d.res_ev = 1'b1;
            s_d.cnt    = '0;
            if (s_q.contin && s_q.start) begin
              s_d.snap_ch  = s_q.hold_ch;
              s_d.snap_ref = s_q.hold_ref;
              s_d.state    = ST_CONV;
            end else begin
              s_d.start = 1'b0;
              s_d.state = ST_IDLE;
            end
          end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
          end
        end
      end
      default: s_d.state = ST_IDLE;
    endcase

    // Set wins over clear
    if (rr_clr) begin
      s_d.rr_flag = 1'b0;
    end
    if (done) begin
      s_d.rr_flag = 1'b1;
    end

    if (!s_q.enable) begin
      s_d.state  = ST_IDLE;
      s_d.start  = 1'b0;
      s_d.sh     = 1'b0;
      s_d.res_ev = 1'b0;
      s_d.cnt    = '0;
    end

    s_d.run  = s_d.enable && (s_d.state != ST_IDLE);
    // Registered copy so the pin comes straight from a flop
    s_d.conv = (s_d.state == ST_CONV);
    s_d.irq = s_d.rr_flag && s_d.rr_ie && GLOBAL_IE;

    // APB: answer prepared during setup, ready in the first access cycle
    s_d.ready  = setup;
    s_d.slverr = setup && !acs_mapped(PADDR);
    s_d.rdata  = ZERO_WORD;
    if (setup && !PWRITE) begin
      case (PADDR)
        ADDR_CTRL: begin
          s_d.rdata[BIT_ENABLE] = s_q.enable;
          s_d.rdata[BIT_CONTIN] = s_q.contin;
        end
        ADDR_CHANNEL: s_d.rdata[CH_W-1:0]  = s_q.hold_ch;
        ADDR_REF:     s_d.rdata[REF_W-1:0] = s_q.hold_ref;
        ADDR_CLOCK_DIVIDER_SELECT:   s_d.rdata[PRE_W-1:0] = s_q.clock_divider_select;
        ADDR_SAMPLE_LENGTH_FIELD: s_d.rdata[LEN_W-1:0] = s_q.sample_length_field;
        ADDR_SAMPLE_DELAY_FIELD: s_d.rdata[DLY_W-1:0] = s_q.sample_delay_field;
        ADDR_EVENT_CONTROL_REGISTER:  s_d.rdata[BIT_ONE]   = s_q.ev_en;
        ADDR_COMMAND: s_d.rdata[BIT_ONE]   = s_q.start;
        ADDR_INTEN:   s_d.rdata[BIT_ONE]   = s_q.rr_ie;
        ADDR_INTERRUPT_FLAG_REGISTER: s_d.rdata[BIT_ONE]   = s_q.rr_flag;
        ADDR_RESULT:  s_d.rdata[RES_W-1:0] = s_q.result;
        ADDR_STATUS: begin
          s_d.rdata[STAT_CH_LSB +: CH_W]   = s_q.act_ch;
          s_d.rdata[STAT_REF_LSB +: REF_W] = s_q.act_ref;
          s_d.rdata[STAT_BUSY]             = (s_q.state != ST_IDLE);
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_lnk.run        = s_q.run;
  assign clk_lnk.factor_sel = s_q.clock_divider_select;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign PRDATA           = s_q.rdata;
  assign PREADY           = s_q.ready;
  assign PSLVERR          = s_q.slverr;
  assign CONV_ACTIVE      = s_q.conv;
  assign SAMPLE_HOLD      = s_q.sh;
  assign ACTIVE_CHANNEL   = s_q.act_ch;
  assign ACTIVE_REFERENCE = s_q.act_ref;
  assign RESULT_EVENT     = s_q.res_ev;
  assign IRQ              = s_q.irq;

endmodule : acs_sequencer

`default_nettype wire

// File: tb/acs_chk.sv
// Port-level assertions for the conversion sequencer.
// Assumes it is bound onto acs_sequencer and sees its ports only.
`default_nettype none

module acs_chk
  import acs_pkg::*;
(
  input wire logic            CLK,
  input wire logic            RESETN,
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [AW-1:0]   PADDR,
  input wire logic [DW-1:0]   PRDATA,
  input wire logic            PREADY,
  input wire logic            GLOBAL_IE,
  input wire logic            CONV_ACTIVE,
  input wire logic            SAMPLE_HOLD,
  input wire logic [CH_W-1:0] ACTIVE_CHANNEL,
  input wire logic            RESULT_EVENT,
  input wire logic            IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  logic rd_acc;
  assign rd_acc = PSEL && PENABLE && PREADY && !PWRITE;

  ////////////////////////////////////////////////////////////////////////////
  property p_ev_pulse; RESULT_EVENT |=> !RESULT_EVENT; endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("result event too long");
  property p_irq_gate; !GLOBAL_IE |=> !IRQ; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  property p_sh_in; SAMPLE_HOLD |-> CONV_ACTIVE; endproperty
  a_sh_in: assert property (p_sh_in) else $error("sample outside conversion");
  property p_sh_late; $rose(CONV_ACTIVE) |-> (!SAMPLE_HOLD) [*3]; endproperty
  a_sh_late: assert property (p_sh_late) else $error("sample too early");
  // Eight cycles is below the shortest conversion, so the final-cycle copy is excluded
  property p_freeze; $rose(CONV_ACTIVE) |=> $stable(ACTIVE_CHANNEL) [*8]; endproperty
  a_freeze: assert property (p_freeze) else $error("channel moved in conversion");
  property p_res_src; RESULT_EVENT |-> $past(CONV_ACTIVE); endproperty
  a_res_src: assert property (p_res_src) else $error("result without conversion");
  property p_busy_rd;
    rd_acc && PADDR == ADDR_COMMAND && CONV_ACTIVE && $past(CONV_ACTIVE) |-> PRDATA[BIT_ONE];
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("start bit low while busy");
  property p_res_w; rd_acc && PADDR == ADDR_RESULT |-> PRDATA[DW-1:RES_W] == '0; endproperty
  a_res_w: assert property (p_res_w) else $error("result not right adjusted");
endmodule : acs_chk

bind acs_sequencer acs_chk u_chk (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .PREADY, .GLOBAL_IE, .CONV_ACTIVE, .SAMPLE_HOLD, .ACTIVE_CHANNEL, .RESULT_EVENT, .IRQ);

`default_nettype wire

// File: tb/acs_core_model.sv
// Behavioural analog core: holds a code made of the selection at sample-hold.
// Assumes the sequencer reads the code before it drops CONV_ACTIVE.
`default_nettype none

module acs_core_model
  import acs_pkg::*;
(
  input wire logic             CLK,
  input wire logic             active,
  input wire logic             hold,
  input wire logic [CH_W-1:0]  ch,
  input wire logic [REF_W-1:0] rf,
  output logic     [RES_W-1:0] res
);
  logic [RES_W-1:0] res_q = 10'h000;

  always @(posedge CLK) if (hold) res_q <= {rf, 2'b01, ch};
  // Inverted when idle so a stale capture cannot pass by luck
  assign res = active ? res_q : ~res_q;
endmodule : acs_core_model

`default_nettype wire

// File: tb/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer.
// Assumes acs_pkg, the core model and the checker bind are compiled first.
`default_nettype none

module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  typedef struct {logic [AW-1:0] a; logic [DW-1:0] w; logic [DW-1:0] r; logic e;} acs_row_s;
  localparam logic [DW-1:0] ONES = 32'hffff_ffff;
  logic clk, rst_n, psel, pen, pwr, ev, gie, conv, sh, rev, irq, pready, pslverr, err, conv_p;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rdv;
  logic [RES_W-1:0] core_res;
  logic [CH_W-1:0] ach, sh_ch[$];
  logic [REF_W-1:0] aref;
  int n_fail, check_count, cyc, t_up, t_sh, t_re, d_re, n_re, hi, n0, k;
  acs_row_s rows[11] = '{
    '{ADDR_CHANNEL, ONES, 32'h1f, 0}, '{ADDR_REF, ONES, 32'h7, 0},
    '{ADDR_CLOCK_DIVIDER_SELECT, ONES, 32'h7, 0}, '{ADDR_SAMPLE_LENGTH_FIELD, ONES, 32'h1f, 0},
    '{ADDR_SAMPLE_DELAY_FIELD, ONES, 32'hf, 0}, '{ADDR_EVENT_CONTROL_REGISTER, ONES, 32'h1, 0},
    '{ADDR_INTEN, ONES, 32'h1, 0}, '{ADDR_CTRL, 32'h2, 32'h2, 0},
    '{ADDR_COMMAND, 32'h1, ZERO_WORD, 0}, '{8'h30, ONES, ZERO_WORD, 1},
    '{8'hfc, ONES, ZERO_WORD, 1}};

  acs_sequencer u_dut (.CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EVENT_IN(ev), .GLOBAL_IE(gie), .CORE_RESULT(core_res), .CONV_ACTIVE(conv),
    .SAMPLE_HOLD(sh), .ACTIVE_CHANNEL(ach), .ACTIVE_REFERENCE(aref), .RESULT_EVENT(rev),
    .IRQ(irq));
  acs_core_model u_core (.CLK(clk), .active(conv), .hold(sh), .ch(ach), .rf(aref),
    .res(core_res));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (conv) hi++;
    if (conv && !conv_p) t_up = cyc;
    if (sh) t_sh = cyc;
    if (sh) sh_ch.push_back(ach);
    if (rev) d_re = cyc - t_re;
    if (rev) t_re = cyc;
    if (rev) n_re++;
    conv_p = conv;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int t;
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t == 50) n_fail++;
    rdv = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    apb(1'b0, a, ZERO_WORD);
    chk(rdv, e);
  endtask : rd

  task automatic wait_re(input int n);
    int w;
    w = 0;
    while (n_re < n && w < 4000) begin
      @(posedge clk);
      w++;
    end
    if (w == 4000) n_fail++;
  endtask : wait_re

  task automatic single(input int s, input int d, input int l, input int ch);
    int f;
    f = 2 << s;
    wr(ADDR_CTRL, ZERO_WORD);
    wr(ADDR_CLOCK_DIVIDER_SELECT, 32'(s));
    wr(ADDR_SAMPLE_DELAY_FIELD, 32'(d));
    wr(ADDR_SAMPLE_LENGTH_FIELD, 32'(l));
    wr(ADDR_CHANNEL, 32'(ch));
    wr(ADDR_REF, 32'h5);
    wr(ADDR_CTRL, 32'h1);
    n0 = n_re;
    hi = 0;
    k = cyc;
    wr(ADDR_COMMAND, 32'h1);
    rd(ADDR_COMMAND, 32'h1);
    repeat (f) @(posedge clk);
    wr(ADDR_CHANNEL, 32'(ch ^ 31));
    wr(ADDR_COMMAND, 32'h1);
    wait_re(n0 + 1);
    repeat (f * 16) @(posedge clk);
    chk(32'(n_re - n0), 32'h1);
    chk(32'(t_up - k - f / 2 inside {[1:5]}), 32'h1);
    chk(32'(hi), 32'((13 + d + l) * f));
    chk(32'(t_sh - t_up), 32'((2 + d + l) * f));
    rd(ADDR_COMMAND, ZERO_WORD);
    rd(ADDR_STATUS, 32'h500 | 32'(ch ^ 31));
    rd(ADDR_INTERRUPT_FLAG_REGISTER, 32'h1);
    rd(ADDR_RESULT, 32'({3'h5, 2'b01, 5'(ch)}));
    rd(ADDR_INTERRUPT_FLAG_REGISTER, ZERO_WORD);
  endtask : single

  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  initial begin
    #(25 * 20000);
    n_fail++;
    close_out();
  end

  initial begin
    rst_n = 0;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    ev = 0;
    gie = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk({conv, sh, rev, irq}, ZERO_WORD);
    for (int a = 0; a < 48; a += 4) rd(AW'(a), ZERO_WORD);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(err, rows[i].e);
      rd(rows[i].a, rows[i].r);
      chk(err, rows[i].e);
    end
    wr(ADDR_EVENT_CONTROL_REGISTER, ZERO_WORD);
    wr(ADDR_INTEN, ZERO_WORD);
    single(0, 0, 0, 5);
    single(1, 3, 2, 9);
    single(2, 15, 31, 22);
    single(0, 0, 0, 3);
    // Interrupt gating and write-one clear
    wr(ADDR_INTEN, 32'h1);
    gie <= 1;
    n0 = n_re;
    wr(ADDR_COMMAND, 32'h1);
    wait_re(n0 + 1);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    gie <= 0;
    repeat (3) @(posedge clk);
    chk(irq, ZERO_WORD);
    gie <= 1;
    wr(ADDR_INTERRUPT_FLAG_REGISTER, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, ZERO_WORD);
    // Long event level starts once, a fresh edge starts again
    wr(ADDR_EVENT_CONTROL_REGISTER, 32'h1);
    n0 = n_re;
    ev <= 1;
    repeat (200) @(posedge clk);
    chk(32'(n_re - n0), 32'h1);
    ev <= 0;
    @(posedge clk);
    ev <= 1;
    @(posedge clk);
    ev <= 0;
    wait_re(n0 + 2);
    chk(32'(n_re - n0), 32'h2);
    // Free-running with a channel change in the first conversion
    wr(ADDR_EVENT_CONTROL_REGISTER, ZERO_WORD);
    wr(ADDR_CHANNEL, 32'h4);
    wr(ADDR_CTRL, 32'h3);
    sh_ch.delete();
    n0 = n_re;
    wr(ADDR_COMMAND, 32'h1);
    k = 0;
    while (!conv && k < 50) begin
      @(posedge clk);
      k++;
    end
    wr(ADDR_CHANNEL, 32'h7);
    rd(ADDR_COMMAND, 32'h1);
    wait_re(n0 + 4);
    chk(32'(d_re), 32'd26);
    wr(ADDR_COMMAND, ZERO_WORD);
    repeat (60) @(posedge clk);
    chk(conv, ZERO_WORD);
    chk(sh_ch[1], 32'h4);
    chk(sh_ch[2], 32'h7);
    close_out();
  end
endmodule : test_adc_conversion_sequencer

`default_nettype wire
